// ### rtl/clmpwm_top.sv
// Closed-loop margining and trim controller for the rail PWM pins
`timescale 1ns/1ns
`default_nettype none
module clmpwm_top #(
	parameter int unsigned NUM_RAILS   = clmpwm_pkg::NUM_RAILS,
	parameter int unsigned LOOP_CYCLES = clmpwm_pkg::LOOP_CYCLES
) (
	input  wire logic                                      sys_clk,
	input  wire logic                                      rst,
	input  wire clmpwm_pkg::clmpwm_rail_cfg_t [NUM_RAILS-1:0] rail_cfg,
	input  wire clmpwm_pkg::clmpwm_mrg_t [NUM_RAILS-1:0]  pmbus_margin,
	input  wire logic [NUM_RAILS-1:0][clmpwm_pkg::VOUT_W-1:0] vout_meas,
	input  wire logic                                      gpi_margin_en,
	input  wire logic                                      gpi_margin_up,
	output var  logic [NUM_RAILS-1:0]                      pwm_out,
	output var  logic [NUM_RAILS-1:0]                      pwm_oe,
	output var  clmpwm_pkg::clmpwm_rail_stat_t [NUM_RAILS-1:0] rail_stat,
	output var  logic                                      loop_tick
);
	import clmpwm_pkg::*;

	localparam int unsigned CNT_W = $clog2(LOOP_CYCLES + 1);

	typedef struct packed {
		logic                                en_a;
		logic                                en_b;
		logic                                up_a;
		logic                                up_b;
		logic [CNT_W-1:0]                    div;
		logic                                tick;
		logic [NUM_RAILS-1:0]                oe;
		clmpwm_rail_stat_t [NUM_RAILS-1:0]   stat;
	} clmpwm_top_st_t;

	clmpwm_top_st_t       st_reg;
	clmpwm_top_st_t       st_next;

	////////////////////////////////////////////////////////////////////////////
	// One loop step: move duty one notch toward the target, saturating
	function automatic logic [DUTY_W-1:0] clmpwm_step(
		input logic [DUTY_W-1:0] duty,
		input logic [VOUT_W-1:0] meas,
		input logic [VOUT_W-1:0] target,
		input logic              inc_raises
	);
		logic raise;
		logic lower;
		logic inc;
		logic dec;
		raise = ({1'b0, meas} + {1'b0, DEADBAND}) < {1'b0, target};
		lower = {1'b0, meas} > ({1'b0, target} + {1'b0, DEADBAND});
		// Polarity picks which way the duty must move for a wanted voltage change
		inc = inc_raises ? raise : lower;
		dec = inc_raises ? lower : raise;
		if (inc) begin
			clmpwm_step = (duty > DUTY_MAX - DUTY_STEP) ? DUTY_MAX : duty + DUTY_STEP;
		end else if (dec) begin
			clmpwm_step = (duty < DUTY_STEP) ? '0 : duty - DUTY_STEP;
		end else begin
			clmpwm_step = duty;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic        pin_req;
		logic        mrg;
		logic        hi;
		logic        pin_src;
		clmpwm_rail_cfg_t cfg;
		pin_req = 1'b0;
		mrg     = 1'b0;
		hi      = 1'b0;
		pin_src = 1'b0;
		cfg     = '0;
		st_next = st_reg;
		// Pins are asynchronous; only the second stage is looked at
		st_next.en_a = gpi_margin_en;
		st_next.en_b = st_reg.en_a;
		st_next.up_a = gpi_margin_up;
		st_next.up_b = st_reg.up_a;
		pin_req = st_reg.en_b;
		// Slow update tick keeps the trim loop well clear of the supply loop
		st_next.tick = 1'b0;
		if (st_reg.div >= CNT_W'(LOOP_CYCLES - 1)) begin
			st_next.div  = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.div = st_reg.div + 1'b1;
		end
		// Requests are only sampled on the tick, so withdrawal lands there too
		if (st_reg.tick) begin
			for (int i = 0; i < NUM_RAILS; i++) begin
				cfg = rail_cfg[i];
				// The PMBus command outranks the pins when both ask
				if (pmbus_margin[i] != CLMPWM_MRG_NONE) begin
					mrg     = 1'b1;
					hi      = (pmbus_margin[i] == CLMPWM_MRG_HIGH);
					pin_src = 1'b0;
				end else if (pin_req) begin
					mrg     = 1'b1;
					hi      = st_reg.up_b;
					pin_src = 1'b1;
				end else begin
					mrg     = 1'b0;
					hi      = 1'b0;
					pin_src = 1'b0;
				end
				st_next.stat[i].margin_active  = mrg;
				st_next.stat[i].margin_high    = mrg & hi;
				st_next.stat[i].fault_suppress = mrg & pin_src & cfg.ignore_faults;
				if (mrg) begin
					st_next.oe[i] = 1'b1;
					st_next.stat[i].duty = clmpwm_step(st_reg.stat[i].duty, vout_meas[i],
						hi ? cfg.vout_high : cfg.vout_low, cfg.inc_raises);
				end else begin
					case (cfg.idle_mode)
						CLMPWM_IDLE_TRIM: begin
							st_next.oe[i] = 1'b1;
							st_next.stat[i].duty = clmpwm_step(st_reg.stat[i].duty,
								vout_meas[i], cfg.vout_nom, cfg.inc_raises);
						end
						CLMPWM_IDLE_FIXED: begin
							st_next.oe[i] = 1'b1;
							st_next.stat[i].duty = cfg.fixed_duty;
						end
						default: begin
							// Duty is kept so a later margin starts from the last value
							st_next.oe[i] = 1'b0;
						end
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg <= '0;
			for (int i = 0; i < NUM_RAILS; i++) begin
				st_reg.stat[i].duty <= DUTY_RST;
			end
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// PWM channels, one per rail
	generate
		for (genvar g = 0; g < NUM_RAILS; g++) begin : g_chan
			clmpwm_chan #(
				.DUTY_W (DUTY_W),
				.PER_W  (PER_W)
			) u_chan (
				.sys_clk (sys_clk),
				.rst     (rst),
				.period  (rail_cfg[g].period),
				.duty    (st_reg.stat[g].duty),
				.pwm     (pwm_out[g])
			);
		end
	endgenerate

	assign pwm_oe    = st_reg.oe;
	assign rail_stat = st_reg.stat;
	assign loop_tick = st_reg.tick;

endmodule // clmpwm_top
`default_nettype wire

// ### pkg/clmpwm_pkg.sv
// Shared constants and types for the rail margining PWM controller
`default_nettype none
package clmpwm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int unsigned NUM_RAILS   = 24;
	localparam int unsigned DUTY_W      = 10;
	localparam int unsigned PER_W       = 16;
	localparam int unsigned VOUT_W      = 12;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned PWM_FMIN_HZ = 1_000;
	localparam int unsigned PWM_FMAX_HZ = 1_000_000;
	// Longest period at the lowest frequency, shortest at the highest
	localparam int unsigned PER_MAX     = CLK_HZ / PWM_FMIN_HZ;
	localparam int unsigned PER_MIN     = (CLK_HZ + PWM_FMAX_HZ - 1) / PWM_FMAX_HZ;
	localparam int unsigned LOOP_PERIOD_US = 1_000;
	localparam int unsigned LOOP_CYCLES = (CLK_HZ / 1_000_000) * LOOP_PERIOD_US;

	////////////////////////////////////////////////////////////////////////////
	// Loop constants and reset values
	localparam logic [DUTY_W-1:0] DUTY_RST  = 10'h200;
	localparam logic [DUTY_W-1:0] DUTY_MAX  = 10'h3ff;
	localparam logic [DUTY_W-1:0] DUTY_STEP = 10'h001;
	localparam logic [VOUT_W-1:0] DEADBAND  = 12'h002;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		CLMPWM_IDLE_TRISTATE = 2'h0,
		CLMPWM_IDLE_TRIM     = 2'h1,
		CLMPWM_IDLE_FIXED    = 2'h3
	} clmpwm_idle_t;

	typedef enum logic [1:0] {
		CLMPWM_MRG_NONE = 2'h0,
		CLMPWM_MRG_LOW  = 2'h1,
		CLMPWM_MRG_HIGH = 2'h3
	} clmpwm_mrg_t;

	typedef struct packed {
		clmpwm_idle_t        idle_mode;
		logic [DUTY_W-1:0]   fixed_duty;
		logic [PER_W-1:0]    period;
		logic                inc_raises;
		logic                ignore_faults;
		logic [VOUT_W-1:0]   vout_nom;
		logic [VOUT_W-1:0]   vout_high;
		logic [VOUT_W-1:0]   vout_low;
	} clmpwm_rail_cfg_t;

	typedef struct packed {
		logic                margin_active;
		logic                margin_high;
		logic                fault_suppress;
		logic [DUTY_W-1:0]   duty;
	} clmpwm_rail_stat_t;

endpackage
`default_nettype wire

// ### rtl/clmpwm_chan.sv
// One PWM channel with period and duty taken at the period boundary
`timescale 1ns/1ns
`default_nettype none
module clmpwm_chan #(
	parameter int unsigned DUTY_W = clmpwm_pkg::DUTY_W,
	parameter int unsigned PER_W  = clmpwm_pkg::PER_W
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [PER_W-1:0]  period,
	input  wire logic [DUTY_W-1:0] duty,
	output var  logic              pwm
);
	import clmpwm_pkg::*;

	typedef struct packed {
		logic [PER_W-1:0] cnt;
		logic [PER_W-1:0] per_l;
		logic [PER_W-1:0] on_l;
		logic             out;
	} clmpwm_chan_st_t;

	clmpwm_chan_st_t              st_reg;
	clmpwm_chan_st_t              st_next;
	logic [PER_W-1:0]             per_c;
	logic [DUTY_W+PER_W-1:0]      prod;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		// Out-of-range settings clamp to the 1 kHz .. 1 MHz window
		if (period < PER_W'(PER_MIN)) begin
			per_c = PER_W'(PER_MIN);
		end else if (period > PER_W'(PER_MAX)) begin
			per_c = PER_W'(PER_MAX);
		end else begin
			per_c = period;
		end
		prod = {{PER_W{1'b0}}, duty} * {{DUTY_W{1'b0}}, per_c};
		st_next = st_reg;
		// New settings only at the boundary, so no runt pulse reaches the filter
		if (st_reg.cnt >= st_reg.per_l - 1'b1) begin
			st_next.cnt   = '0;
			st_next.per_l = per_c;
			st_next.on_l  = prod[DUTY_W+PER_W-1:DUTY_W];
		end else begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
		st_next.out = (st_reg.cnt < st_reg.on_l);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_reg       <= '0;
			st_reg.per_l <= PER_W'(PER_MIN);
		end else begin
			st_reg <= st_next;
		end
	end

	assign pwm = st_reg.out;

endmodule // clmpwm_chan
`default_nettype wire

// ### dv/clmpwm_rail_model.sv
// Behavioural RC filter and supply feedback node for one rail
`timescale 1ns/1ns
`default_nettype none
module clmpwm_rail_model (
	input  wire logic        sys_clk,
	input  wire logic        pwm,
	input  wire logic        oe,
	input  wire logic        inc_raises,
	output wire logic [11:0] vout
);
	int v = 2048;
	////////////////////////////////////////
	// Slow filter; a floating pin leaves the node at mid scale
	// Unknown drive before reset counts as floating, so the node never collapses to zero
	always @(posedge sys_clk)
		v <= v + (((oe === 1'b1) ? ((pwm === 1'b1) ? 4095 : 0) : 2048) - v) / 1024;
	// Injection polarity decides which way duty moves the rail
	assign vout = inc_raises ? 12'(v) : 12'(4095 - v);
endmodule // clmpwm_rail_model
`default_nettype wire

// ### dv/clmpwm_sva.sv
// Port assertions for the rail margining controller
`timescale 1ns/1ns
`default_nettype none
module clmpwm_sva #(
	parameter int unsigned NUM_RAILS   = 24,
	parameter int unsigned LOOP_CYCLES = 50000
) (
	input wire logic                                          sys_clk,
	input wire logic                                          rst,
	input wire clmpwm_pkg::clmpwm_rail_cfg_t [NUM_RAILS-1:0]  rail_cfg,
	input wire clmpwm_pkg::clmpwm_mrg_t [NUM_RAILS-1:0]       pmbus_margin,
	input wire logic [NUM_RAILS-1:0][clmpwm_pkg::VOUT_W-1:0] vout_meas,
	input wire logic                                          gpi_margin_en,
	input wire logic                                          gpi_margin_up,
	input wire logic [NUM_RAILS-1:0]                          pwm_out,
	input wire logic [NUM_RAILS-1:0]                          pwm_oe,
	input wire clmpwm_pkg::clmpwm_rail_stat_t [NUM_RAILS-1:0] rail_stat,
	input wire logic                                          loop_tick
);
	import clmpwm_pkg::*;
	// Pin history, so idle checks skip ticks where the synchroniser lags
	logic [2:0] en_h;
	logic       idl;
	always_ff @(posedge sys_clk) en_h <= {en_h[1:0], gpi_margin_en};
	assign idl = loop_tick && pmbus_margin[0] == CLMPWM_MRG_NONE && en_h == 3'h0 && !gpi_margin_en;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	a_tick_spacing: assert property (loop_tick |=> !loop_tick [*8])
		else $error("loop update too frequent");
	a_stat_hold: assert property (!loop_tick |=> $stable(rail_stat))
		else $error("rail status moved between updates");
	a_oe_hold: assert property (!loop_tick |=> $stable(pwm_oe))
		else $error("pin drive moved between updates");
	a_duty_step: assert property (loop_tick && pmbus_margin[0] != CLMPWM_MRG_NONE |=>
		10'(rail_stat[0].duty - $past(rail_stat[0].duty) + 10'h1) <= 10'h2)
		else $error("margin duty step larger than one");
	a_pmbus_high: assert property (loop_tick && pmbus_margin[0] == CLMPWM_MRG_HIGH |=>
		rail_stat[0].margin_active && rail_stat[0].margin_high &&
		pwm_oe[0] && !rail_stat[0].fault_suppress)
		else $error("bus margin high not taken");
	// Rail 1 has fault suppression configured, so only here does this check bite
	a_pmbus_nosup: assert property (loop_tick && pmbus_margin[1] != CLMPWM_MRG_NONE |=>
		rail_stat[1].margin_active && !rail_stat[1].fault_suppress)
		else $error("bus margin suppressed faults");
	a_dir_up: assert property (loop_tick && pmbus_margin[0] == CLMPWM_MRG_HIGH &&
		rail_cfg[0].inc_raises && rail_stat[0].duty != DUTY_MAX &&
		{1'b0, vout_meas[0]} + 13'h3 <= {1'b0, rail_cfg[0].vout_high} |=>
		rail_stat[0].duty == $past(rail_stat[0].duty) + 10'h1)
		else $error("duty did not rise toward target");
	a_fixed_duty: assert property (idl && rail_cfg[0].idle_mode == CLMPWM_IDLE_FIXED |=>
		pwm_oe[0] && rail_stat[0].duty == $past(rail_cfg[0].fixed_duty))
		else $error("fixed idle duty wrong");
	a_tri_float: assert property (idl && rail_cfg[0].idle_mode == CLMPWM_IDLE_TRISTATE |=>
		!pwm_oe[0] && $stable(rail_stat[0].duty))
		else $error("tristate idle pin driven");
endmodule // clmpwm_sva
bind clmpwm_top clmpwm_sva #(.NUM_RAILS(NUM_RAILS), .LOOP_CYCLES(LOOP_CYCLES)) u_sva (
	.sys_clk(sys_clk), .rst(rst), .rail_cfg(rail_cfg), .pmbus_margin(pmbus_margin),
	.vout_meas(vout_meas), .gpi_margin_en(gpi_margin_en), .gpi_margin_up(gpi_margin_up),
	.pwm_out(pwm_out), .pwm_oe(pwm_oe), .rail_stat(rail_stat), .loop_tick(loop_tick));
`default_nettype wire

// ### dv/clmpwm_top_bench.sv
// Self-checking bench for the rail margining controller
`timescale 1ns/1ns
`default_nettype none
module clmpwm_top_bench;
	import clmpwm_pkg::*;
	logic                             sys_clk, rst, gpi_margin_en, gpi_margin_up, loop_tick;
	clmpwm_rail_cfg_t [NUM_RAILS-1:0] rail_cfg;
	clmpwm_mrg_t [NUM_RAILS-1:0]      pmbus_margin;
	wire logic [NUM_RAILS-1:0][VOUT_W-1:0] vout_meas;
	logic [NUM_RAILS-1:0]             pwm_out, pwm_oe;
	clmpwm_rail_stat_t [NUM_RAILS-1:0] rail_stat;
	logic [DUTY_W-1:0]                exp_duty [NUM_RAILS];
	int                               err_count = 0;
	int                               cmp_count = 0;
	initial begin
		sys_clk = 0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Short loop period keeps the run brief
	clmpwm_top #(.LOOP_CYCLES(16)) uut (.sys_clk(sys_clk), .rst(rst), .rail_cfg(rail_cfg),
		.pmbus_margin(pmbus_margin), .vout_meas(vout_meas), .gpi_margin_en(gpi_margin_en),
		.gpi_margin_up(gpi_margin_up), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
		.rail_stat(rail_stat), .loop_tick(loop_tick));
	for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
		clmpwm_rail_model u_rc (.sys_clk(sys_clk), .pwm(pwm_out[i]), .oe(pwm_oe[i]),
			.inc_raises(rail_cfg[i].inc_raises), .vout(vout_meas[i]));
	end
	////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk iff loop_tick === 1'b1);
		#2;
	endtask
	task set_pm(input clmpwm_mrg_t m);
		foreach (pmbus_margin[i]) pmbus_margin[i] = m;
	endtask
	task set_idle(input clmpwm_idle_t m);
		foreach (rail_cfg[i]) rail_cfg[i].idle_mode = m;
	endtask
	// Every tick moves each rail one step; hi means the target sits above the rail
	task run(input logic hi, input int n, input logic act, input logic mhi);
		repeat (n) begin
			tick(1);
			for (int i = 0; i < NUM_RAILS; i++) begin
				exp_duty[i] = (hi == rail_cfg[i].inc_raises) ? exp_duty[i] + DUTY_STEP :
					exp_duty[i] - DUTY_STEP;
				chk(rail_stat[i].duty, exp_duty[i]);
				chk({rail_stat[i].margin_active, rail_stat[i].margin_high, pwm_oe[i]},
					{act, mhi, 1'b1});
			end
		end
	endtask
	////////////////////////////////////////
	task t_reset;
		foreach (exp_duty[i]) exp_duty[i] = DUTY_RST;
		foreach (rail_stat[i]) chk(rail_stat[i], 32'(DUTY_RST));
		chk(pwm_oe, 0);
		chk(pwm_out, 0);
		chk(loop_tick, 0);
	endtask
	task t_pmbus;
		set_pm(CLMPWM_MRG_HIGH);
		run(1'b1, 4, 1'b1, 1'b1);
		foreach (rail_stat[i]) chk(rail_stat[i].fault_suppress, 1'b0);
		set_pm(CLMPWM_MRG_LOW);
		run(1'b0, 4, 1'b1, 1'b0);
	endtask
	task t_pins;
		set_pm(CLMPWM_MRG_NONE);
		gpi_margin_en = 1;
		gpi_margin_up = 1;
		run(1'b1, 2, 1'b1, 1'b1);
		foreach (rail_stat[i]) chk(rail_stat[i].fault_suppress, rail_cfg[i].ignore_faults);
		gpi_margin_up = 0;
		run(1'b0, 2, 1'b1, 1'b0);
	endtask
	task t_fixed;
		logic [31:0] hi_cnt;
		hi_cnt = 0;
		gpi_margin_en = 0;
		set_idle(CLMPWM_IDLE_FIXED);
		tick(1);
		foreach (exp_duty[i]) exp_duty[i] = 10'h155;
		foreach (rail_stat[i]) chk({rail_stat[i].margin_active, pwm_oe[i], rail_stat[i].duty},
			{2'b01, 10'h155});
		repeat (100) @(posedge sys_clk);
		// Sample off the edge so the count never races the channel's own update
		repeat (50) begin
			@(posedge sys_clk);
			#2;
			hi_cnt += pwm_out[0];
		end
		chk(hi_cnt, (32'h155 * 50) >> 10);
	endtask
	task t_idle;
		set_idle(CLMPWM_IDLE_TRIM);
		run(1'b1, 3, 1'b0, 1'b0);
		set_idle(CLMPWM_IDLE_TRISTATE);
		tick(1);
		foreach (rail_stat[i]) chk({pwm_oe[i], rail_stat[i].duty}, {1'b0, exp_duty[i]});
	endtask
	task stop_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		rst = 1;
		gpi_margin_en = 0;
		gpi_margin_up = 0;
		set_pm(CLMPWM_MRG_NONE);
		foreach (rail_cfg[i]) rail_cfg[i] = '{idle_mode: CLMPWM_IDLE_TRISTATE,
			fixed_duty: 10'h155, period: 16'h0032, inc_raises: !i[0], ignore_faults: i[0],
			vout_nom: 12'hfa0, vout_high: 12'hfa0, vout_low: 12'h00a};
		repeat (20) @(posedge sys_clk);
		#2;
		rst = 0;
		t_reset;
		t_pmbus;
		t_pins;
		t_fixed;
		t_idle;
		stop_test;
	end
	// About thirty loop updates are needed; allow ten times that
	initial begin
		#100000;
		err_count++;
		stop_test;
	end
endmodule // clmpwm_top_bench
`default_nettype wire
